// ### hdl/spi_port_pkg.sv
// Purpose: shared constants for the serial port block
// Assumes: 8-bit register offsets on a 32-bit AXI4-Lite bus
// Notes:   rate table holds full periods of the serial clock in system clocks
package spi_port_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_DATA       = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
  localparam logic [7:0] ADDR_PIN_CFG    = 8'h14;

  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [5:0] PIN_CFG_RESET   = 6'h00;
  localparam logic [2:0] IRQ_RESET       = 3'h0;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_IRQ_EN    = 7;
  localparam int CTL_PORT_EN   = 6;
  localparam int CTL_BIT_ORDER = 5;
  localparam int CTL_MASTER    = 4;
  localparam int CTL_CLOCK_POLARITY      = 3;
  localparam int CTL_CLOCK_PHASE      = 2;
  localparam int CTL_RATE_HI   = 1;
  localparam int CTL_RATE_LO   = 0;
  localparam int STAT_DONE     = 7;
  localparam int STAT_WRITE_COLLISION_FLAG     = 6;
  localparam int STAT_DOUBLE   = 0;
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_WRITE_COLLISION_FLAG      = 1;
  localparam int IRQ_FAULT     = 2;
  localparam int PIN_DIR_MOSI  = 0;
  localparam int PIN_DIR_MISO  = 1;
  localparam int PIN_DIR_SCK   = 2;
  localparam int PIN_DIR_SS    = 3;
  localparam int PIN_SS_LEVEL  = 4;
  localparam int PIN_GIE       = 5;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SCK_DIV_0 = 4;
  localparam int SCK_DIV_1 = 16;
  localparam int SCK_DIV_2 = 64;
  localparam int SCK_DIV_3 = 128;
  localparam int SCK_DIV_4 = 2;
  localparam int SCK_DIV_5 = 8;
  localparam int SCK_DIV_6 = 32;
  localparam int SCK_DIV_7 = 64;
  localparam logic [3:0] LAST_EDGE = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : spi_port_pkg

// ### hdl/spi_rate_div.sv
// Purpose: half-period tick generator for the master serial clock
// Assumes: half_count is at least 1 and stable while run is high
// Notes:   tick is a one-cycle pulse
`timescale 1ns/100ps
module spi_rate_div (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [6:0] half_count,
  output logic            tick
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } div_s;

  div_s s;
  div_s n;

  always_comb
  begin
    n = s;
    n.tick = 1'b0;
    if (!run)
    begin
      n.cnt = 7'h00;
    end
    else if (s.cnt == 7'(half_count - 7'h01))
    begin
      n.cnt  = 7'h00;
      n.tick = 1'b1;
    end
    else
    begin
      n.cnt = 7'(s.cnt + 7'h01);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= n;
  end

  assign tick = s.tick;

endmodule : spi_rate_div

// ### hdl/spi_shifter.sv
// Purpose: eight-bit shift register with bit counter
// Assumes: at most one of sample_en and setup_en per cycle
// Notes:   byte_done pulses one cycle after the eighth sample
`timescale 1ns/100ps
module spi_shifter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  input  wire logic       lsb_first,
  input  wire logic       sample_en,
  input  wire logic       setup_en,
  input  wire logic       in_bit,
  output logic            out_bit,
  output logic [7:0]      shift_data,
  output logic            busy,
  output logic            byte_done
);

  typedef struct packed {
    logic [7:0] sr;
    logic [2:0] in_cnt;
    logic       out_bit;
    logic       done;
  } shift_s;

  shift_s s;
  shift_s n;

  always_comb
  begin
    n = s;
    n.done = 1'b0;
    if (clear)
      n.in_cnt = 3'h0;
    if (load)
    begin
      n.sr      = load_data;
      n.in_cnt  = 3'h0;
      n.out_bit = lsb_first ? load_data[0] : load_data[7];
    end
    else if (sample_en && !clear)
    begin
      n.sr     = lsb_first ? {in_bit, s.sr[7:1]} : {s.sr[6:0], in_bit};
      n.in_cnt = 3'(s.in_cnt + 3'h1);
      n.done   = (s.in_cnt == 3'h7);
    end
    else if (setup_en && !clear)
    begin
      n.out_bit = lsb_first ? s.sr[0] : s.sr[7];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= n;
  end

  assign out_bit    = s.out_bit;
  assign shift_data = s.sr;
  assign busy       = (s.in_cnt != 3'h0);
  assign byte_done  = s.done;

endmodule : spi_shifter

// ### hdl/spi_master_slave_port.sv
// Purpose: byte-wide serial port, master or slave, behind AXI4-Lite
// Assumes: pin inputs synchronous to aclk; slave serial clock at most aclk/4
// Notes:   one write and one read in flight on the bus at a time
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps

module spi_master_slave_port (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        vector_ack,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_i,
  output logic             ss_o,
  output logic             ss_oe,
  output logic             spi_irq,
  output logic             irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_END} run_e;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  ctl;
    logic        dbl;
    logic        done_flag;
    logic        write_collision_flag_flag;
    logic        armed;
    logic [7:0]  rx_buf;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [5:0]  pin_cfg;
    run_e        mode;
    logic [3:0]  edge_cnt;
    logic        sck;
    logic        sck_prev;
    logic        sck_oe;
    logic        mosi_oe;
    logic        miso_oe;
    logic        ss_o;
    logic        ss_oe;
    logic        spi_irq;
    logic        irq;
  } port_s;

  port_s       s;
  port_s       n;
  logic        tick;
  logic        sh_out;
  logic [7:0]  sh_data;
  logic        sh_busy;
  logic        sh_done;
  logic        sh_clear;
  logic        sh_load;
  logic        sh_sample;
  logic        sh_setup;
  logic [6:0]  half_count;
  logic        en;
  logic        master;
  logic        slave_on;
  logic        do_write;
  logic        do_read;
  logic        data_access;
  logic        ev_done;
  logic        ev_write_collision_flag;
  logic        ev_fault;
  logic        leading;
  logic        trailing;

  // ************************************************************
  // rate selection
  // ************************************************************
  always_comb
  begin
    case ({s.dbl, s.ctl[spi_port_pkg::CTL_RATE_HI], s.ctl[spi_port_pkg::CTL_RATE_LO]})
      3'h0:    half_count = 7'(spi_port_pkg::SCK_DIV_0 / 2);
      3'h1:    half_count = 7'(spi_port_pkg::SCK_DIV_1 / 2);
      3'h2:    half_count = 7'(spi_port_pkg::SCK_DIV_2 / 2);
      3'h3:    half_count = 7'(spi_port_pkg::SCK_DIV_3 / 2);
      3'h4:    half_count = 7'(spi_port_pkg::SCK_DIV_4 / 2);
      3'h5:    half_count = 7'(spi_port_pkg::SCK_DIV_5 / 2);
      3'h6:    half_count = 7'(spi_port_pkg::SCK_DIV_6 / 2);
      default: half_count = 7'(spi_port_pkg::SCK_DIV_7 / 2);
    endcase
  end

  spi_rate_div u_div (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .run        (s.mode == ST_RUN),
    .half_count (half_count),
    .tick       (tick)
  );

  spi_shifter u_shift (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clear      (sh_clear),
    .load       (sh_load),
    .load_data  (s.wdata),
    .lsb_first  (s.ctl[spi_port_pkg::CTL_BIT_ORDER]),
    .sample_en  (sh_sample),
    .setup_en   (sh_setup),
    .in_bit     (master ? miso_i : mosi_i),
    .out_bit    (sh_out),
    .shift_data (sh_data),
    .busy       (sh_busy),
    .byte_done  (sh_done)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    n = s;
    en          = s.ctl[spi_port_pkg::CTL_PORT_EN];
    master      = s.ctl[spi_port_pkg::CTL_MASTER];
    slave_on    = en && !master && !ss_i;
    do_write    = s.aw_got && s.w_got && !s.bvalid;
    do_read     = arvalid && s.arready;
    data_access = (do_read && araddr == spi_port_pkg::ADDR_DATA)
               || (do_write && s.awaddr == spi_port_pkg::ADDR_DATA && s.wstrb0);
    ev_done     = 1'b0;
    ev_write_collision_flag     = 1'b0;
    ev_fault    = 1'b0;
    sh_load     = 1'b0;
    sh_clear    = en && !master && ss_i;
    n.sck_prev  = sck_i;
    leading     = slave_on && (s.sck_prev == s.ctl[spi_port_pkg::CTL_CLOCK_POLARITY])
                           && (sck_i != s.ctl[spi_port_pkg::CTL_CLOCK_POLARITY]);
    trailing    = slave_on && (s.sck_prev != s.ctl[spi_port_pkg::CTL_CLOCK_POLARITY])
                           && (sck_i == s.ctl[spi_port_pkg::CTL_CLOCK_POLARITY]);
    if (s.mode == ST_RUN)
    begin
      leading  = tick && !s.edge_cnt[0];
      trailing = tick && s.edge_cnt[0];
    end
    sh_sample = s.ctl[spi_port_pkg::CTL_CLOCK_PHASE] ? trailing : leading;
    sh_setup  = s.ctl[spi_port_pkg::CTL_CLOCK_PHASE] ? leading : trailing;

    // bus channels
    if (awvalid && s.awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      n.w_got  = 1'b1;
      n.wdata  = wdata[7:0];
      n.wstrb0 = wstrb[0];
    end
    if (s.bvalid && bready)
      n.bvalid = 1'b0;
    if (s.rvalid && rready)
      n.rvalid = 1'b0;

    // master transfer and slave byte capture
    if (s.mode == ST_RUN && tick)
    begin
      n.sck      = !s.sck;
      n.edge_cnt = 4'(s.edge_cnt + 4'h1);
      if (s.edge_cnt == spi_port_pkg::LAST_EDGE)
        n.mode = ST_END;
    end
    if (s.mode == ST_END)
    begin
      n.mode   = ST_IDLE;
      ev_done  = 1'b1;
      n.rx_buf = sh_data;
    end
    if (sh_done && !master)
    begin
      ev_done  = 1'b1;
      n.rx_buf = sh_data;
    end
    if (s.mode != ST_RUN)
      n.sck = s.ctl[spi_port_pkg::CTL_CLOCK_POLARITY];

    // register reads
    if (do_read)
    begin
      n.rvalid = 1'b1;
      n.rresp  = spi_port_pkg::RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      case (araddr)
        spi_port_pkg::ADDR_CONTROL:    n.rdata[7:0] = s.ctl;
        spi_port_pkg::ADDR_STATUS:
        begin
          n.rdata[spi_port_pkg::STAT_DONE]   = s.done_flag;
          n.rdata[spi_port_pkg::STAT_WRITE_COLLISION_FLAG]   = s.write_collision_flag_flag;
          n.rdata[spi_port_pkg::STAT_DOUBLE] = s.dbl;
          if (s.done_flag || s.write_collision_flag_flag)
            n.armed = 1'b1;
        end
        spi_port_pkg::ADDR_DATA:       n.rdata[7:0] = s.rx_buf;
        spi_port_pkg::ADDR_IRQ_STATUS: n.rdata[2:0] = s.irq_stat;
        spi_port_pkg::ADDR_IRQ_MASK:   n.rdata[2:0] = s.irq_mask;
        spi_port_pkg::ADDR_PIN_CFG:    n.rdata[5:0] = s.pin_cfg;
        default:                       n.rresp = spi_port_pkg::RESP_SLVERR;
      endcase
    end

    // register writes
    if (do_write)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = spi_port_pkg::RESP_OKAY;
      case (s.awaddr)
        spi_port_pkg::ADDR_CONTROL:
          if (s.wstrb0)
            n.ctl = s.wdata;
        spi_port_pkg::ADDR_STATUS:
          if (s.wstrb0)
            n.dbl = s.wdata[spi_port_pkg::STAT_DOUBLE];
        spi_port_pkg::ADDR_DATA:
          if (s.wstrb0)
          begin
            if (s.mode != ST_IDLE || (slave_on && sh_busy))
              ev_write_collision_flag = 1'b1;
            else
            begin
              sh_load = 1'b1;
              if (en && master)
              begin
                n.mode     = ST_RUN;
                n.edge_cnt = 4'h0;
              end
            end
          end
        spi_port_pkg::ADDR_IRQ_STATUS:
          if (s.wstrb0)
            n.irq_stat = s.irq_stat & ~s.wdata[2:0];
        spi_port_pkg::ADDR_IRQ_MASK:
          if (s.wstrb0)
            n.irq_mask = s.wdata[2:0];
        spi_port_pkg::ADDR_PIN_CFG:
          if (s.wstrb0)
            n.pin_cfg = s.wdata[5:0];
        default: n.bresp = spi_port_pkg::RESP_SLVERR;
      endcase
    end

    // another master pulled select low
    if (en && master && !s.pin_cfg[spi_port_pkg::PIN_DIR_SS] && !ss_i)
    begin
      n.ctl[spi_port_pkg::CTL_MASTER] = 1'b0;
      ev_done  = 1'b1;
      ev_fault = 1'b1;
      n.mode   = ST_IDLE;
      sh_clear = 1'b1;
    end
    if (!en)
      n.mode = ST_IDLE;

    // flags: a clear never hides an event in the same cycle
    if (vector_ack)
      n.done_flag = 1'b0;
    if (data_access && s.armed)
    begin
      n.done_flag = 1'b0;
      n.write_collision_flag_flag = 1'b0;
      n.armed     = 1'b0;
    end
    n.done_flag = n.done_flag | ev_done;
    n.write_collision_flag_flag = n.write_collision_flag_flag | ev_write_collision_flag;
    n.irq_stat  = n.irq_stat | {ev_fault, ev_write_collision_flag, ev_done};

    // pins, ready lines and interrupts, registered
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
    n.sck_oe  = n.ctl[spi_port_pkg::CTL_PORT_EN] && n.ctl[spi_port_pkg::CTL_MASTER]
             && n.pin_cfg[spi_port_pkg::PIN_DIR_SCK];
    n.mosi_oe = n.ctl[spi_port_pkg::CTL_PORT_EN] && n.ctl[spi_port_pkg::CTL_MASTER]
             && n.pin_cfg[spi_port_pkg::PIN_DIR_MOSI];
    n.miso_oe = n.ctl[spi_port_pkg::CTL_PORT_EN] && !n.ctl[spi_port_pkg::CTL_MASTER]
             && !ss_i && n.pin_cfg[spi_port_pkg::PIN_DIR_MISO];
    n.ss_oe   = n.ctl[spi_port_pkg::CTL_PORT_EN] && n.ctl[spi_port_pkg::CTL_MASTER]
             && n.pin_cfg[spi_port_pkg::PIN_DIR_SS];
    n.ss_o    = n.pin_cfg[spi_port_pkg::PIN_SS_LEVEL];
    n.spi_irq = n.ctl[spi_port_pkg::CTL_IRQ_EN] && n.done_flag
             && n.pin_cfg[spi_port_pkg::PIN_GIE];
    n.irq     = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s          <= '0;
      s.ctl      <= spi_port_pkg::CONTROL_RESET;
      s.pin_cfg  <= spi_port_pkg::PIN_CFG_RESET;
      s.irq_stat <= spi_port_pkg::IRQ_RESET;
      s.irq_mask <= spi_port_pkg::IRQ_RESET;
      s.mode     <= ST_IDLE;
    end
    else
      s <= n;
  end

  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
  assign sck_o   = s.sck;
  assign sck_oe  = s.sck_oe;
  assign mosi_o  = sh_out;
  assign mosi_oe = s.mosi_oe;
  assign miso_o  = sh_out;
  assign miso_oe = s.miso_oe;
  assign ss_o    = s.ss_o;
  assign ss_oe   = s.ss_oe;
  assign spi_irq = s.spi_irq;
  assign irq     = s.irq;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_irq_gate: assert property (
    s.spi_irq |-> s.ctl[spi_port_pkg::CTL_IRQ_EN] && s.done_flag
                  && s.pin_cfg[spi_port_pkg::PIN_GIE])
    else $error("port interrupt without enable and flag");
  a_ctl_reset: assert property (
    !$past(aresetn) |-> s.ctl == spi_port_pkg::CONTROL_RESET)
    else $error("control register not zero after reset");
  a_rate_div16: assert property (
    (s.mode == ST_RUN && $changed(s.sck) && !s.dbl && s.ctl[1:0] == 2'h1)
      |=> $stable(s.sck)[*7])
    else $error("serial clock half period is not eight cycles");
  a_master_done: assert property (
    s.mode == ST_END |=> s.done_flag && s.mode == ST_IDLE)
    else $error("master end did not set done flag");
  a_slave_done: assert property (
    (sh_done && !master) |=> s.done_flag && s.rx_buf == $past(sh_data))
    else $error("slave byte not flagged or not buffered");
  a_rx_read: assert property (
    (do_read && araddr == spi_port_pkg::ADDR_DATA) |=> s.rdata[7:0] == $past(s.rx_buf))
    else $error("data read did not return receive buffer");
  a_slave_miso: assert property (
    s.miso_oe |-> !$past(ss_i) && !s.ctl[spi_port_pkg::CTL_MASTER])
    else $error("data out driven while deselected or master");
  a_mode_fault: assert property (
    (en && master && !s.pin_cfg[spi_port_pkg::PIN_DIR_SS] && !ss_i)
      |=> !s.ctl[spi_port_pkg::CTL_MASTER] && s.done_flag && s.mode == ST_IDLE)
    else $error("select low did not drop master role");
  a_write_coll: assert property (
    (do_write && s.wstrb0 && s.awaddr == spi_port_pkg::ADDR_DATA && s.mode == ST_RUN)
      |=> s.write_collision_flag_flag && s.edge_cnt == $past(s.edge_cnt) + ($past(tick) ? 4'h1 : 4'h0))
    else $error("collision not flagged or transfer disturbed");

endmodule : spi_master_slave_port

// ### sim/spi_far_slave.sv
// Purpose: far-side slave used while the port is master
// Assumes: clock idles low, sample on rising edge, msb first
// Notes:   miso shows the inverse of its last bit while deselected
`timescale 1ns/100ps
module spi_far_slave (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  // ****
  // shifting
  // ****
  logic [7:0] shift_reg;

  initial shift_reg = 8'h00;
  assign miso = sel_n ? ~shift_reg[7] : shift_reg[7];

  always @(negedge sel_n) shift_reg = tx_byte;
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) if (!sel_n) shift_reg = {shift_reg[6:0], 1'b0};
endmodule : spi_far_slave

// ### sim/tb_spi_master_slave_port.sv
// Purpose: self-checking bench for the serial port block
// Assumes: far slave model runs mode 0, msb first
// Notes:   expected receive bytes queue up in exp_q
`timescale 1ns/100ps
module tb_spi_master_slave_port;
  // ****
  // signals
  // ****
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, vector_ack;
  logic        awready, wready, bvalid, arready, rvalid, spi_irq, irq;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic        sck_drv, mosi_drv, ss_drv, far_miso, sck_q;
  logic [7:0]  awaddr, araddr, far_tx, far_rx, got, val, rx, seen;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  exp_q[$];
  int          fails, total_checks, seed, cyc, last_rise, sck_per;
  wire logic   sck_i  = sck_oe ? sck_o : sck_drv;
  wire logic   mosi_i = mosi_oe ? mosi_o : mosi_drv;
  wire logic   miso_i = miso_oe ? miso_o : far_miso;
  wire logic   ss_i   = ss_oe ? ss_o : ss_drv;

  spi_master_slave_port spi_master_slave_port_i (.*);
  spi_far_slave spi_far_slave_i (.sck(sck_i), .mosi(mosi_i), .sel_n(ss_i),
    .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // sck period monitor and hang limit
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    sck_q <= sck_o;
    if (sck_o && !sck_q)
    begin
      sck_per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc > 5000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // ****
  // tasks
  // ****
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen_v);
    total_checks++;
    if (seen_v !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen_v);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    resp = rresp;
    chk(what, exp, rdata[7:0]);
  endtask : rchk

  task automatic master_xfer(input logic [7:0] tx, input int mode);
    far_tx = 8'($random(seed));
    exp_q.push_back(far_tx);
    wr(spi_port_pkg::ADDR_PIN_CFG, 8'h3D);
    chk("select pin", 8'h03, {6'h00, ss_oe, ss_o});
    wr(spi_port_pkg::ADDR_PIN_CFG, 8'h2D);
    wr(spi_port_pkg::ADDR_DATA, tx);
    if (mode == 1) wr(spi_port_pkg::ADDR_DATA, ~tx);
    do @(posedge aclk); while (spi_irq !== 1'b1);
    chk("sck period", 8'(spi_port_pkg::SCK_DIV_1), 8'(sck_per));
    chk("far rx", tx, far_rx);
    chk("master enables", 8'h06, {5'h00, sck_oe, mosi_oe, miso_oe});
    wr(spi_port_pkg::ADDR_PIN_CFG, 8'h0D);
    repeat (3) @(posedge aclk);
    chk("irq lines", 8'h01, {6'h00, spi_irq, irq});
    wr(spi_port_pkg::ADDR_IRQ_STATUS, 8'h07);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 8'h00, {7'h00, irq});
    if (mode == 2)
    begin
      vector_ack <= 1'b1;
      @(posedge aclk);
      vector_ack <= 1'b0;
      rchk(spi_port_pkg::ADDR_STATUS, 8'h00, "vector clear");
    end
    else
      rchk(spi_port_pkg::ADDR_STATUS, mode ? 8'hC0 : 8'h80, "done");
    rchk(spi_port_pkg::ADDR_DATA, exp_q.pop_front(), "rx buffer");
    rchk(spi_port_pkg::ADDR_STATUS, 8'h00, "flags cleared");
    rchk(spi_port_pkg::ADDR_CONTROL, 8'hD1, "control kept");
  endtask : master_xfer

  task automatic slave_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_drv <= b[i];
      repeat (4) @(posedge aclk);
      seen[i] = miso_i;
      sck_drv <= 1'b1;
      repeat (4) @(posedge aclk);
      sck_drv <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask : slave_byte

  // ****
  // sequence
  // ****
  initial
  begin
    seed = 99572;
    {awvalid, wvalid, bready, arvalid, rready, vector_ack, sck_drv, mosi_drv} = '0;
    {awaddr, araddr, wdata, far_tx} = '0;
    wstrb = 4'hF;
    ss_drv = 1'b1;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(spi_port_pkg::ADDR_CONTROL, spi_port_pkg::CONTROL_RESET, "control reset");
    rchk(8'h18, 8'h00, "unmapped");
    chk("unmapped resp", {6'h00, spi_port_pkg::RESP_SLVERR}, {6'h00, resp});
    wr(8'h18, 8'h00);
    chk("unmapped bresp", {6'h00, spi_port_pkg::RESP_SLVERR}, {6'h00, resp});
    repeat (4)
    begin
      val = 8'($random(seed)) & 8'hBF;
      wr(spi_port_pkg::ADDR_CONTROL, val);
      rchk(spi_port_pkg::ADDR_CONTROL, val, "control rw");
    end
    wr(spi_port_pkg::ADDR_IRQ_MASK, 8'h07);
    wr(spi_port_pkg::ADDR_CONTROL, 8'hD1);
    for (int m = 0; m < 3; m++) master_xfer(8'($random(seed)), m);
    wr(spi_port_pkg::ADDR_CONTROL, 8'hC0);
    wr(spi_port_pkg::ADDR_PIN_CFG, 8'h22);
    val = 8'($random(seed));
    wr(spi_port_pkg::ADDR_DATA, val);
    slave_byte(8'h5A);
    rchk(spi_port_pkg::ADDR_STATUS, 8'h00, "deselected");
    rx = 8'($random(seed));
    exp_q.push_back(rx);
    ss_drv <= 1'b0;
    slave_byte(rx);
    chk("slave enables", 8'h01, {5'h00, sck_oe, mosi_oe, miso_oe});
    chk("miso bits", val, seen);
    ss_drv <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("miso released", 8'h00, {7'h00, miso_oe});
    rchk(spi_port_pkg::ADDR_STATUS, 8'h80, "slave done");
    rchk(spi_port_pkg::ADDR_DATA, exp_q.pop_front(), "slave rx");
    chk("irq set", 8'h01, {7'h00, irq});
    wr(spi_port_pkg::ADDR_IRQ_MASK, 8'h00);
    repeat (3) @(posedge aclk);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(spi_port_pkg::ADDR_CONTROL, 8'h50);
    wr(spi_port_pkg::ADDR_PIN_CFG, 8'h25);
    ss_drv <= 1'b0;
    repeat (3) @(posedge aclk);
    rchk(spi_port_pkg::ADDR_CONTROL, 8'h40, "master dropped");
    rchk(spi_port_pkg::ADDR_STATUS, 8'h80, "fault flag");
    tally_and_finish();
  end
endmodule : tb_spi_master_slave_port
